// >>> logic/ttt_pkg.sv
// package of constants and types for the trigger tag table
// Function
// RULE1: a trigger is a one-cycle high pulse on the bunch_crossing_clock
// RULE2: each of 15 trigger codes makes its own four-cycle pulse pattern
// RULE3: command triggers win over self-triggers when both arrive
// RULE4: a trigger only labels data with an identifier, readout starts later
// RULE5: fixed latency from trigger to output start is at least 31 cycles
// RULE6: tag base is one of 54 balanced 6-bit symbols
// RULE7: extended tag is tag base plus two bits naming the crossing
// RULE8: tag ranges: 0-215 command, 216-219 bit flip, 220-223 unknown, 224-255 self
// RULE9: a trigger asking for a tag still in use is dropped and counted
// RULE10: controller never requests a tag in use, fresh base each command; tb_top reuses one base while its tag is held
// RULE11: main table has 256 rows, row number is the trigger identifier
// RULE12: identifiers assigned sequentially, Gray coded on the matrix bus
// RULE13: each main row stores the extended tag and a state
// RULE14: each column keeps its own 256-row table drained independently
// RULE15: trigger takes next empty row, sends identifier, stores tag, marks triggered
// RULE16: new row goes empty to pending readout in all columns at once
// RULE17: column serves oldest row: readout, then clear, then empty
// RULE18: a column readout spends at least 3 cycles
// RULE19: main row empties when event is handed to the encoder, tag emitted
// RULE20: per-row age counter compared with a programmable timeout limit
// RULE21: on timeout, unprocessed columns go pending_clear_state and main row empties
// RULE22: self-triggers take sequential tags in 224-255, reset by clear pulse
// RULE23: no empty row available means the trigger is dropped and counted
package ttt_pkg;
    localparam int TTT_ROWS = 256;
    localparam int TTT_ROW_W = 8;
    localparam int TTT_TAG_W = 8;
    localparam int TTT_BASE_W = 6;
    localparam int TTT_CODE_W = 4;
    localparam int TTT_CMD_CYCLES = 4;
    localparam int TTT_CNT_W = 16;
    localparam logic [7:0] TTT_CMD_TAG_MAX = 8'hd7;
    localparam logic [7:0] TTT_FLIP_TAG_BASE = 8'hd8;
    localparam logic [7:0] TTT_BAD_TAG_BASE = 8'hdc;
    localparam logic [7:0] TTT_SELF_TAG_FIRST = 8'he0;
    localparam logic [7:0] TTT_SELF_TAG_LAST = 8'hff;
    localparam int TTT_MIN_LATENCY_BX = 31;
    localparam int TTT_TOKEN_BX = 3;
    localparam int TTT_ENCODE_BX = 3;
    localparam int TTT_READ_MIN_BX = 3;
    localparam int TTT_BX_MHZ = 40;
    localparam int TTT_READ_CYCLES = TTT_READ_MIN_BX;
    localparam logic [15:0] TTT_TIMEOUT_RESET = 16'h0100;

    typedef enum logic [1:0] {
        TTT_EMPTY = 2'b00,
        TTT_PENDING_READOUT = 2'b01,
        TTT_PENDING_CLEAR = 2'b10
    } ttt_row_state_t;

    function automatic logic [7:0] ttt_gray(input logic [7:0] b);
        ttt_gray = b ^ {1'b0, b[7:1]};
    endfunction : ttt_gray
endpackage : ttt_pkg

// >>> logic/ttt_cmd_expand.sv
// expands a trigger command code into four cycles of pulses and tags
`timescale 1ns/1ps
module ttt_cmd_expand
    import ttt_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cmd_valid_in,
    input wire logic [3:0] cmd_code_in,
    input wire logic [5:0] cmd_base_in,
    input wire logic [1:0] cmd_base_err_in,
    output logic trig_out,
    output logic [7:0] tag_out
);
    typedef struct packed {
        logic [3:0] pattern;
        logic [1:0] slot;
        logic [5:0] base;
        logic [1:0] err;
        logic trig;
        logic [7:0] tag;
    } ttt_exp_t;
    ttt_exp_t state, next_state;

    function automatic logic [7:0] make_tag(input logic [5:0] b, input logic [1:0] s, input logic [1:0] e);
        unique case (e)
            2'b01: make_tag = TTT_FLIP_TAG_BASE | {6'h00, s}; // see RULE8
            2'b10: make_tag = TTT_BAD_TAG_BASE | {6'h00, s}; // see RULE8
            default: make_tag = {b, s}; // see RULE7
        endcase
    endfunction : make_tag

    always_comb begin
        next_state = state;
        next_state.trig = 1'b0;
        if (state.pattern != 4'h0) begin
            next_state.trig = state.pattern[3]; // see RULE1
            next_state.tag = make_tag(state.base, state.slot, state.err);
            next_state.pattern = {state.pattern[2:0], 1'b0};
            next_state.slot = state.slot + 2'd1;
        end
        if (cmd_valid_in && cmd_code_in != 4'h0) begin
            next_state.trig = cmd_code_in[3]; // see RULE2
            next_state.tag = make_tag(cmd_base_in, 2'd0, cmd_base_err_in);
            next_state.pattern = {cmd_code_in[2:0], 1'b0};
            next_state.slot = 2'd1;
            next_state.base = cmd_base_in; // see RULE6
            next_state.err = cmd_base_err_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign trig_out = state.trig;
    assign tag_out = state.tag;

    AST_ONE_CYCLE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE1
        (cmd_valid_in && cmd_code_in == 4'h8 && state.pattern == 4'h0) |=> trig_out ##1 !trig_out)
        else $error("single trigger not one cycle");
    AST_TAG_SLOT: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE7
        (cmd_valid_in && cmd_code_in == 4'h1 && cmd_base_err_in == 2'b00) |=> ##3 (trig_out && tag_out[1:0] == 2'd3))
        else $error("last slot tag wrong");
endmodule : ttt_cmd_expand

// >>> logic/ttt_column.sv
// one core column table with its own readout state machine
`timescale 1ns/1ps
module ttt_column
    import ttt_pkg::*;
#(
    parameter int ROWS = TTT_ROWS
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic fill_in,
    input wire logic [7:0] fill_row_in,
    input wire logic [ROWS-1:0] timeout_in,
    input wire logic done_in,
    output logic busy_out,
    output logic [7:0] read_row_out,
    output logic reading_out,
    output logic clearing_out
);
    typedef enum logic [1:0] {
        COL_IDLE = 2'b00,
        COL_READ = 2'b01,
        COL_CLEAR = 2'b10
    } ttt_col_fsm_t;
    typedef struct packed {
        logic [ROWS-1:0][1:0] rows;
        logic [7:0] head;
        ttt_col_fsm_t fsm;
        logic [1:0] wait_cnt;
    } ttt_col_t;
    ttt_col_t state, next_state;

    always_comb begin
        next_state = state;
        for (int i = 0; i < ROWS; i++) begin
            if (timeout_in[i] && state.rows[i] == TTT_PENDING_READOUT) begin
                next_state.rows[i] = TTT_PENDING_CLEAR; // see RULE21
            end
        end
        unique case (state.fsm)
            COL_IDLE: begin
                if (state.rows[state.head] == TTT_PENDING_READOUT) begin
                    next_state.fsm = COL_READ; // see RULE17
                    next_state.wait_cnt = 2'(TTT_READ_CYCLES - 1);
                end else if (state.rows[state.head] == TTT_PENDING_CLEAR) begin
                    next_state.fsm = COL_CLEAR;
                end
            end
            COL_READ: begin
                if (state.wait_cnt != 2'd0) begin
                    next_state.wait_cnt = state.wait_cnt - 2'd1; // see RULE18
                end else if (done_in) begin
                    next_state.rows[state.head] = TTT_PENDING_CLEAR; // see RULE17
                    next_state.fsm = COL_CLEAR;
                end
            end
            COL_CLEAR: begin
                next_state.rows[state.head] = TTT_EMPTY; // see RULE17
                next_state.head = state.head + 8'd1;
                next_state.fsm = COL_IDLE;
            end
            default: next_state.fsm = COL_IDLE;
        endcase
        if (fill_in) begin
            next_state.rows[fill_row_in] = TTT_PENDING_READOUT; // see RULE16
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign busy_out = (state.fsm != COL_IDLE);
    assign read_row_out = state.head;
    assign reading_out = (state.fsm == COL_READ);
    assign clearing_out = (state.fsm == COL_CLEAR);

    AST_READ_MIN: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE18
        $rose(reading_out) |-> reading_out [*3])
        else $error("column read shorter than minimum");
endmodule : ttt_column

// >>> logic/ttt_top.sv
// trigger tag table: main table, arbitration, column tables, timeouts
`timescale 1ns/1ps
module ttt_top
    import ttt_pkg::*;
#(
    parameter int COLS = 2,
    parameter int ROWS = TTT_ROWS
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic cmd_valid_in,
    input wire logic [3:0] cmd_code_in,
    input wire logic [5:0] cmd_base_in,
    input wire logic [1:0] cmd_base_err_in,
    input wire logic self_trig_in,
    input wire logic datapath_clear_pulse_in,
    input wire logic [15:0] row_timeout_limit_in,
    input wire logic [COLS-1:0] col_done_in,
    input wire logic event_handoff_in,
    output logic trig_pulse_out,
    output logic [7:0] trig_id_gray_out,
    output logic [COLS-1:0] col_reading_out,
    output logic [COLS*8-1:0] col_row_out,
    output logic event_valid_out,
    output logic [7:0] event_tag_out,
    output logic [15:0] skipped_count_out
);
    logic [1:0] rst_sync;
    logic rst_n;
    logic cmd_trig;
    logic [7:0] cmd_tag;
    logic [COLS-1:0] col_busy;
    logic [COLS-1:0] col_reading;
    logic [COLS-1:0] col_clearing;
    logic [COLS-1:0][7:0] col_row;

    typedef struct packed {
        logic [ROWS-1:0][7:0] tags;
        logic [ROWS-1:0] used;
        logic [ROWS-1:0][15:0] age;
        logic [ROWS-1:0] timeout;
        logic [7:0] wr_ptr;
        logic [7:0] rd_ptr;
        logic [7:0] self_tag;
        logic fill;
        logic [7:0] fill_row;
        logic trig;
        logic [7:0] id_gray;
        logic ev_valid;
        logic [7:0] ev_tag;
        logic [15:0] skipped;
        logic [COLS-1:0] reading;
        logic [COLS*8-1:0] rows_out;
    } ttt_main_t;
    ttt_main_t state, next_state;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ttt_cmd_expand u_expand (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .cmd_valid_in(cmd_valid_in),
        .cmd_code_in(cmd_code_in),
        .cmd_base_in(cmd_base_in),
        .cmd_base_err_in(cmd_base_err_in),
        .trig_out(cmd_trig),
        .tag_out(cmd_tag)
    );

    for (genvar c = 0; c < COLS; c++) begin : g_col // see RULE14
        ttt_column #(.ROWS(ROWS)) u_col (
            .clk_in(clk_in),
            .rst_n_in(rst_n),
            .fill_in(state.fill),
            .fill_row_in(state.fill_row),
            .timeout_in(state.timeout),
            .done_in(col_done_in[c]),
            .busy_out(col_busy[c]),
            .read_row_out(col_row[c]),
            .reading_out(col_reading[c]),
            .clearing_out(col_clearing[c])
        );
        AST_COL_CLEAR_ONE: assert property (@(posedge clk_in) disable iff (!rst_n) // see RULE17
            col_clearing[c] |=> !col_busy[c])
            else $error("column clear longer than one cycle");
    end

    function automatic logic tag_in_use(input ttt_main_t s, input logic [7:0] t);
        tag_in_use = 1'b0;
        for (int i = 0; i < ROWS; i++) begin
            if (s.used[i] && s.tags[i] == t) begin
                tag_in_use = 1'b1;
            end
        end
    endfunction : tag_in_use

    // hand-off only counts once the oldest row has aged past the fixed latency
    function automatic logic handoff_ok(input ttt_main_t s, input logic h);
        handoff_ok = h && s.used[s.rd_ptr] && (s.age[s.rd_ptr] >= 16'(TTT_MIN_LATENCY_BX)); // see RULE5
    endfunction : handoff_ok

    always_comb begin
        logic want;
        logic [7:0] tag;
        logic dup;
        want = 1'b0;
        tag = 8'h00;
        dup = 1'b0;
        next_state = state;
        next_state.fill = 1'b0;
        next_state.trig = 1'b0;
        next_state.ev_valid = 1'b0;
        next_state.timeout = '0;
        if (datapath_clear_pulse_in) begin
            next_state.self_tag = TTT_SELF_TAG_FIRST; // see RULE22
        end
        if (cmd_trig) begin
            want = 1'b1; // see RULE3
            tag = cmd_tag;
        end else if (self_trig_in) begin
            want = 1'b1;
            tag = state.self_tag; // see RULE22
            if (!datapath_clear_pulse_in) begin
                next_state.self_tag = (state.self_tag == TTT_SELF_TAG_LAST) ? TTT_SELF_TAG_FIRST
                                                                            : state.self_tag + 8'd1;
            end
        end
        // per-row aging while the main row is in use
        for (int i = 0; i < ROWS; i++) begin
            if (state.used[i]) begin
                next_state.age[i] = state.age[i] + 16'd1; // see RULE20
                if (state.age[i] >= row_timeout_limit_in) begin
                    next_state.timeout[i] = 1'b1; // see RULE21
                end
            end
        end
        // main row retires on hand-off or timeout
        if (state.used[state.rd_ptr] && (handoff_ok(state, event_handoff_in) || state.timeout[state.rd_ptr])) begin
            next_state.used[state.rd_ptr] = 1'b0; // see RULE19
            next_state.rd_ptr = state.rd_ptr + 8'd1;
            next_state.ev_valid = handoff_ok(state, event_handoff_in); // see RULE5
            next_state.ev_tag = state.tags[state.rd_ptr]; // see RULE13
        end else if (!state.used[state.rd_ptr] && state.rd_ptr != state.wr_ptr) begin
            next_state.rd_ptr = state.rd_ptr + 8'd1;
        end
        dup = tag_in_use(state, tag);
        if (want) begin
            if (dup) begin
                next_state.skipped = state.skipped + 16'd1; // see RULE9
            end else if (state.used[state.wr_ptr]) begin
                next_state.skipped = state.skipped + 16'd1; // see RULE23
            end else begin
                next_state.used[state.wr_ptr] = 1'b1; // see RULE15
                next_state.tags[state.wr_ptr] = tag; // see RULE13
                next_state.age[state.wr_ptr] = 16'd0;
                next_state.wr_ptr = state.wr_ptr + 8'd1; // see RULE12
                next_state.trig = 1'b1; // see RULE4
                next_state.id_gray = ttt_gray(state.wr_ptr); // see RULE12
                next_state.fill = 1'b1; // see RULE16
                next_state.fill_row = state.wr_ptr; // see RULE11
            end
        end
        next_state.reading = col_reading;
        next_state.rows_out = col_row;
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
            state.self_tag <= TTT_SELF_TAG_FIRST;
        end else begin
            state <= next_state;
        end
    end

    assign trig_pulse_out = state.trig;
    assign trig_id_gray_out = state.id_gray;
    assign col_reading_out = state.reading;
    assign col_row_out = state.rows_out;
    assign event_valid_out = state.ev_valid;
    assign event_tag_out = state.ev_tag;
    assign skipped_count_out = state.skipped;

    AST_GRAY_STEP: assert property (@(posedge clk_in) disable iff (!rst_n) // see RULE12
        $changed(trig_id_gray_out) |-> trig_pulse_out && ($countones(trig_id_gray_out ^ $past(trig_id_gray_out)) == 1))
        else $error("gray id changed in more than one bit");
    AST_CMD_WINS: assert property (@(posedge clk_in) disable iff (!rst_n) // see RULE3
        (cmd_trig && self_trig_in) |=> $stable(state.self_tag) || $past(datapath_clear_pulse_in))
        else $error("self trigger taken over command");
    AST_SELF_RANGE: assert property (@(posedge clk_in) disable iff (!rst_n) // see RULE22
        state.self_tag >= TTT_SELF_TAG_FIRST)
        else $error("self tag outside range");
    AST_DUP_SKIP: assert property (@(posedge clk_in) disable iff (!rst_n) // see RULE9
        (cmd_trig && tag_in_use(state, cmd_tag)) |=> (skipped_count_out == $past(skipped_count_out) + 16'd1) && !trig_pulse_out)
        else $error("duplicate tag not skipped");
    AST_FILL_ID: assert property (@(posedge clk_in) disable iff (!rst_n) // see RULE15
        state.fill |-> trig_pulse_out && trig_id_gray_out == ttt_gray(state.fill_row))
        else $error("fill row and id differ");
    AST_HANDOFF_EMPTY: assert property (@(posedge clk_in) disable iff (!rst_n) // see RULE19
        handoff_ok(state, event_handoff_in) |=> event_valid_out && !state.used[$past(state.rd_ptr)])
        else $error("row not emptied on hand-off");
    AST_TIMEOUT: assert property (@(posedge clk_in) disable iff (!rst_n) // see RULE21
        (state.timeout[state.rd_ptr] && state.used[state.rd_ptr]) |=> !state.used[$past(state.rd_ptr)])
        else $error("timed out row not emptied");
endmodule : ttt_top

// >>> bench/ttt_daq_model.sv
// behavioural acquisition controller issuing trigger commands
`timescale 1ns/1ps
module ttt_daq_model (
    input wire logic clk_in,
    output logic cmd_valid_out,
    output logic [3:0] cmd_code_out,
    output logic [5:0] cmd_base_out,
    output logic [1:0] cmd_base_err_out
);
    logic [5:0] base_ctr = 6'h00;

    initial begin
        cmd_valid_out = 1'b0;
        cmd_code_out = 4'h0;
        cmd_base_out = 6'h00;
        cmd_base_err_out = 2'b00;
    end

    // fresh base for every command, wrapping to 0 after 0x35 without checking hand-off
    function automatic logic [5:0] fresh_base();
        base_ctr = (base_ctr == 6'h35) ? 6'h00 : base_ctr + 6'h01;
        return base_ctr;
    endfunction : fresh_base

    // one-cycle command, fields scrambled while idle
    task automatic send(input logic [3:0] code, input logic [5:0] base, input logic [1:0] err);
        cmd_valid_out = 1'b1;
        cmd_code_out = code;
        cmd_base_out = base % 6'h36;
        cmd_base_err_out = err;
        @(posedge clk_in);
        #1;
        cmd_valid_out = 1'b0;
        cmd_code_out = ~code;
        cmd_base_out = ~cmd_base_out;
        cmd_base_err_out = ~err;
    endtask : send
endmodule : ttt_daq_model

// >>> bench/tb_top.sv
// self-checking testbench of the trigger tag table
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module tb_top;
    import ttt_pkg::*;
    localparam int COLS = 2;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic cmd_valid_in;
    logic [3:0] cmd_code_in;
    logic [5:0] cmd_base_in;
    logic [1:0] cmd_base_err_in;
    logic self_trig_in = 1'b0;
    logic datapath_clear_pulse_in = 1'b0;
    logic event_handoff_in = 1'b0;
    logic [15:0] row_timeout_limit_in = 16'hffff;
    logic [COLS-1:0] col_done_in = '1;
    logic trig_pulse_out;
    logic event_valid_out;
    logic [7:0] trig_id_gray_out;
    logic [7:0] event_tag_out;
    logic [COLS-1:0] col_reading_out;
    logic [COLS*8-1:0] col_row_out;
    logic [15:0] skipped_count_out;
    logic [7:0] exp_id[$];
    logic [7:0] exp_tag[$];
    logic [7:0] next_row = 8'h00;
    logic [7:0] ex_i;
    logic [7:0] ex_t;
    logic [7:0] row_t;
    logic [5:0] b;
    logic [15:0] exp_skip = 16'h0000;
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 19;

    always #5 clk_in = ~clk_in;

    ttt_daq_model i_daq (.clk_in(clk_in), .cmd_valid_out(cmd_valid_in), .cmd_code_out(cmd_code_in),
        .cmd_base_out(cmd_base_in), .cmd_base_err_out(cmd_base_err_in));

    ttt_top #(.COLS(COLS)) i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid_in),
        .cmd_code_in(cmd_code_in), .cmd_base_in(cmd_base_in), .cmd_base_err_in(cmd_base_err_in),
        .self_trig_in(self_trig_in), .datapath_clear_pulse_in(datapath_clear_pulse_in),
        .row_timeout_limit_in(row_timeout_limit_in), .col_done_in(col_done_in),
        .event_handoff_in(event_handoff_in), .trig_pulse_out(trig_pulse_out),
        .trig_id_gray_out(trig_id_gray_out), .col_reading_out(col_reading_out), .col_row_out(col_row_out),
        .event_valid_out(event_valid_out), .event_tag_out(event_tag_out), .skipped_count_out(skipped_count_out));

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cycles

    // note one accepted trigger: next sequential row and its tag
    task automatic expect_trig(input logic [7:0] tag);
        exp_id.push_back(next_row ^ {1'b0, next_row[7:1]});
        exp_tag.push_back(tag);
        next_row = next_row + 8'h01;
    endtask : expect_trig

    // command with slot mask; dup marks slots whose tag is still held
    task automatic cmd(input logic [3:0] code, input logic [5:0] base, input logic [1:0] err, input logic [3:0] dup);
        for (int s = 0; s < 4; s++) begin
            if (code[3 - s]) begin
                if (dup[3 - s]) exp_skip = exp_skip + 16'h0001;
                else if (err == 2'b00) expect_trig({base, s[1:0]});
                else expect_trig((err == 2'b01 ? TTT_FLIP_TAG_BASE : TTT_BAD_TAG_BASE) + 8'(s));
            end
        end
        i_daq.send(code, base, err);
        cycles(6);
    endtask : cmd

    task automatic self_pulse();
        expect_trig(TTT_SELF_TAG_FIRST + ex_t);
        ex_t = ex_t + 8'h01;
        self_trig_in = 1'b1;
        cycles(1);
        self_trig_in = 1'b0;
        cycles(4);
    endtask : self_pulse

    task automatic hand_off(input int n);
        repeat (n) begin
            event_handoff_in = 1'b1;
            cycles(1);
            event_handoff_in = 1'b0;
            cycles(3);
        end
    endtask : hand_off

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    // result watcher: oldest note against each output event
    always @(negedge clk_in) begin
        if (trig_pulse_out === 1'b1) begin
            ex_i = (exp_id.size() > 0) ? exp_id.pop_front() : 8'hxx;
            `CHK(trig_id_gray_out, ex_i)
        end
        if (event_valid_out === 1'b1) begin
            row_t = (exp_tag.size() > 0) ? exp_tag.pop_front() : 8'hxx;
            `CHK(event_tag_out, row_t)
        end
    end

    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        ex_t = 8'h00;
        i_daq.base_ctr = 6'($unsigned($random(seed)) % 54);
        cycles(5);
        reset_n_in = 1'b1;
        cycles(5);
        datapath_clear_pulse_in = 1'b1;
        cycles(1);
        datapath_clear_pulse_in = 1'b0;
        for (int c = 1; c < 16; c++) begin
            cmd(4'(c), i_daq.fresh_base(), 2'b00, 4'h0);
            cycles($unsigned($random(seed)) % 4);
        end
        cycles(200);
        hand_off(32);
        cmd(4'hf, i_daq.fresh_base(), 2'b01, 4'h0);
        cmd(4'hf, i_daq.fresh_base(), 2'b10, 4'h0);
        cycles(60);
        hand_off(8);
        b = i_daq.fresh_base();
        cmd(4'h8, b, 2'b00, 4'h0);
        cmd(4'h8, b, 2'b00, 4'h8);
        cmd(4'hc, b, 2'b00, 4'h8);
        `CHK(skipped_count_out, exp_skip)
        cycles(30);
        hand_off(2);
        repeat (3) self_pulse();
        fork
            cmd(4'hf, i_daq.fresh_base(), 2'b00, 4'h0);
            begin
                cycles(2);
                self_trig_in = 1'b1;
                cycles(3);
                self_trig_in = 1'b0;
            end
        join
        self_pulse();
        cycles(60);
        hand_off(8);
        col_done_in = '0;
        row_timeout_limit_in = 16'h0010;
        b = i_daq.fresh_base();
        row_t = next_row;
        cmd(4'h8, b, 2'b00, 4'h0);
        void'(exp_tag.pop_back());
        `CHK(col_reading_out, 2'b11)
        `CHK(col_row_out, {row_t, row_t})
        hand_off(1);
        cycles(40);
        cmd(4'h8, b, 2'b00, 4'h0);
        row_timeout_limit_in = 16'hffff;
        col_done_in = '1;
        cycles(30);
        hand_off(1);
        cycles(20);
        `CHK(skipped_count_out, exp_skip)
        `CHK(exp_id.size(), 0)
        `CHK(exp_tag.size(), 0)
        report_and_stop();
    end
endmodule : tb_top
